// ==== logic/ircx_pkg.sv ====
package ircx_pkg;

  // ----------------------------------------------------------------------
  // Widths and address layout
  // ----------------------------------------------------------------------
  localparam int          RX_CNT_W      = 12;
  localparam int          TX_CNT_W      = 12;
  localparam int          FEP_W         = 14;
  localparam int          ADDR_IDX_LSB  = 2;
  localparam int          ADDR_BANK_LSB = 5;
  localparam int          ADDR_MAP_TOP  = 7;

  localparam logic [1:0]  BANK_CNT      = 2'h1;
  localparam logic [1:0]  BANK_CFG      = 2'h2;
  localparam logic [2:0]  IDX_RXC_LO    = 3'h2;
  localparam logic [2:0]  IDX_RXC_HI    = 3'h3;
  localparam logic [2:0]  IDX_FEP_LO    = 3'h4;
  localparam logic [2:0]  IDX_FEP_HI    = 3'h5;
  localparam logic [2:0]  IDX_TXC_LO    = 3'h6;
  localparam logic [2:0]  IDX_TXC_HI    = 3'h7;
  localparam logic [2:0]  IDX_IRCFG     = 3'h1;
  localparam logic [2:0]  IDX_XCVR      = 3'h2;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int          IRCFG_SPEED_LSB = 4;
  localparam int          IRCFG_MOD_LSB   = 0;
  localparam int          XCVR_GPIO_A     = 7;
  localparam int          XCVR_GPIO_B     = 6;
  localparam int          XCVR_GPIO_C     = 5;
  localparam int          XCVR_SHDN       = 4;
  localparam int          XCVR_ECHO       = 3;
  localparam int          XCVR_ACT        = 2;
  localparam int          XCVR_TXD_FORCE  = 1;
  localparam int          XCVR_GPIO_D     = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  IRCFG_RST     = 8'h00;
  localparam logic [7:0]  XCVR_RST      = 8'h00;
  localparam logic [11:0] RXC_RST       = 12'h000;
  localparam logic [11:0] TXC_RST       = 12'h000;
  localparam logic [13:0] FEP_RST       = 14'h0000;

  // ----------------------------------------------------------------------
  // Modulation and fast-mode rate codes
  // ----------------------------------------------------------------------
  localparam logic [3:0]  MOD_SIR       = 4'h0;
  localparam logic [3:0]  MOD_ASK       = 4'h1;
  localparam logic [3:0]  MOD_FIR1      = 4'h2;
  localparam logic [3:0]  MOD_REMOTE    = 4'h3;
  localparam logic [3:0]  MOD_FIR4      = 4'h4;
  localparam logic [3:0]  RATE_1152K    = 4'h0;
  localparam logic [3:0]  RATE_576K     = 4'h1;
  localparam logic [3:0]  RATE_288K     = 4'h2;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr_pend;
    logic [4:0] wr_key;
  } ircx_ahb_st_t;

  typedef struct packed {
    logic [11:0] rx_cnt;
    logic [13:0] fep;
    logic [5:0]  fep_hi_snap;
    logic [11:0] tx_cnt;
    logic [7:0]  ircfg;
    logic [7:0]  xcvr;
    logic [7:0]  rdata;
    logic        shdn;
    logic        txd;
    logic        sir_rx;
  } ircx_core_st_t;

  function automatic logic [4:0] ircx_key(input logic [1:0] bank, input logic [2:0] idx);
    return {bank, idx};
  endfunction

endpackage

// ==== logic/ircx_ahb_slave.sv ====
`timescale 1ns/100ps
module ircx_ahb_slave (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic        hready_in,
  output logic             rd_stb_out,
  output logic [4:0]       rd_key_out,
  output logic             wr_stb_out,
  output logic [4:0]       wr_key_out
);
  import ircx_pkg::*;

  ircx_ahb_st_t st_r;
  ircx_ahb_st_t st_nxt;
  logic         take;

  // ----------------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------------
  // Reads act in the address phase so that the read data can be registered
  // for the data phase; writes act in the data phase when the data exists.
  assign take       = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
  assign rd_stb_out = take && !hwrite_in;
  assign rd_key_out = haddr_in[ADDR_MAP_TOP-1:ADDR_IDX_LSB];
  assign wr_stb_out = st_r.wr_pend;
  assign wr_key_out = st_r.wr_key;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.wr_pend = take && hwrite_in;
    if (take && hwrite_in) begin
      st_nxt.wr_key = haddr_in[ADDR_MAP_TOP-1:ADDR_IDX_LSB];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  property p_wr_one_shot;
    @(posedge clk_in) disable iff (!rstn_in)
      (take && hwrite_in) |=> (wr_stb_out && wr_key_out == $past(haddr_in[6:2]));
  endproperty
  a_wr_one_shot: assert property (p_wr_one_shot) else $error("write strobe missing after write address phase");

endmodule

// ==== logic/ircx_regs.sv ====
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
// Functional notes
// - Twelve-bit receive byte count, two read bytes.
// - Fourteen-bit frame end pointer, low and high.
// - Frame end pointer resets to zero.
// - Transmit count decrements on each queue write, holds at zero.
// - Zero count stops DMA; queue still drains.
// - Speed field codes fast-mode data rate.
// - Speed ignored in serial and keyed modes.
// - Modulation field selects the mode.
// - Control bits 7,6,5,0 drive general pins.
// - Bit 4 drives shutdown; power-down forces it.
// - Bit 3 loops modulated transmit to receive.
// - Bit 2 drives activity pin, inhibits power-down.
// - Bit 1 forces transmit pin, resets zero.
module ircx_regs #(
  parameter int RXC_W = ircx_pkg::RX_CNT_W,
  parameter int TXC_W = ircx_pkg::TX_CNT_W,
  parameter int PTR_W = ircx_pkg::FEP_W
) (
  input  wire logic        CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        RX_START_IN,
  input  wire logic        RX_BYTE_IN,
  input  wire logic        RX_FRAME_END_IN,
  input  wire logic [13:0] RX_END_PTR_IN,
  input  wire logic        TXQ_WRITE_IN,
  input  wire logic        TX_DMA_RAW_IN,
  input  wire logic        TXQ_EMPTY_IN,
  output logic             TX_DMA_REQ_OUT,
  output logic             TX_DONE_OUT,
  input  wire logic        PWRDN_REQ_IN,
  output logic             PWRDN_OUT,
  input  wire logic        TXD_MOD_IN,
  input  wire logic        RX_PIN_IN,
  output logic             SIR_RX_OUT,
  output logic             TXD_OUT,
  output logic             GPIO_A_OUT,
  output logic             GPIO_B_OUT,
  output logic             GPIO_C_OUT,
  output logic             GPIO_D_OUT,
  output logic             XCVR_SHDN_OUT,
  output logic             IR_ACT_OUT,
  output logic [3:0]       MODE_OUT,
  output logic [3:0]       FIR_RATE_OUT,
  output logic             USE_DIVISOR_OUT,
  output logic             CFG_RESERVED_OUT
);
  import ircx_pkg::*;

  if (RXC_W != RX_CNT_W || TXC_W != TX_CNT_W || PTR_W != FEP_W) begin : g_width_check
    $error("ircx_regs: field widths are fixed by the register layout");
  end

  ircx_core_st_t st_r;
  ircx_core_st_t st_nxt;
  logic          rd_stb;
  logic [4:0]    rd_key;
  logic          wr_stb;
  logic [4:0]    wr_key;
  logic [7:0]    wbyte;
  logic [3:0]    mode;
  logic [3:0]    speed;
  logic          pd_eff;

  // ----------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------
  ircx_ahb_slave u_ahb (
    .clk_in     (CLK_IN),
    .rstn_in    (RSTN_IN),
    .hsel_in    (HSEL_IN),
    .haddr_in   (HADDR_IN),
    .htrans_in  (HTRANS_IN),
    .hwrite_in  (HWRITE_IN),
    .hready_in  (HREADY_IN),
    .rd_stb_out (rd_stb),
    .rd_key_out (rd_key),
    .wr_stb_out (wr_stb),
    .wr_key_out (wr_key)
  );

  // Addresses above the decoded window alias nothing: they are unmapped.
  logic hi_zero_rd;
  logic hi_zero_wr_r;
  assign hi_zero_rd    = (HADDR_IN[31:ADDR_MAP_TOP] == '0);
  assign wbyte         = HWDATA_IN[7:0];
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  assign HRDATA_OUT    = {24'h000000, st_r.rdata};

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      hi_zero_wr_r <= 1'b0;
    end else begin
      hi_zero_wr_r <= hi_zero_rd;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------------
  assign mode   = st_r.ircfg[IRCFG_MOD_LSB+:4];
  assign speed  = st_r.ircfg[IRCFG_SPEED_LSB+:4];
  // An active infrared link holds the controller out of power-down.
  assign pd_eff = PWRDN_REQ_IN && !st_r.xcvr[XCVR_ACT];

  assign MODE_OUT         = mode;
  assign USE_DIVISOR_OUT  = (mode == MOD_SIR) || (mode == MOD_ASK);
  assign FIR_RATE_OUT     = (mode == MOD_FIR1) ? speed : RATE_1152K;
  assign CFG_RESERVED_OUT = (mode > MOD_FIR4) ||
                            ((mode == MOD_FIR1) && (speed > RATE_288K));
  assign PWRDN_OUT        = pd_eff;

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  assign GPIO_A_OUT     = st_r.xcvr[XCVR_GPIO_A];
  assign GPIO_B_OUT     = st_r.xcvr[XCVR_GPIO_B];
  assign GPIO_C_OUT     = st_r.xcvr[XCVR_GPIO_C];
  assign GPIO_D_OUT     = st_r.xcvr[XCVR_GPIO_D];
  assign IR_ACT_OUT     = st_r.xcvr[XCVR_ACT];
  assign XCVR_SHDN_OUT  = st_r.shdn;
  assign TXD_OUT        = st_r.txd;
  assign SIR_RX_OUT     = st_r.sir_rx;

  // ----------------------------------------------------------------------
  // Transmit pacing
  // ----------------------------------------------------------------------
  // Requests stop once the count is spent; the transmitter keeps draining.
  assign TX_DMA_REQ_OUT = TX_DMA_RAW_IN && (st_r.tx_cnt != '0);
  assign TX_DONE_OUT    = (st_r.tx_cnt == '0) && TXQ_EMPTY_IN;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    if (RX_START_IN) begin
      st_nxt.rx_cnt = RX_BYTE_IN ? 12'h001 : RXC_RST;
    end else if (RX_BYTE_IN) begin
      st_nxt.rx_cnt = st_r.rx_cnt + 12'h001;
    end

    if (RX_FRAME_END_IN) begin
      st_nxt.fep = RX_END_PTR_IN;
    end

    if (TXQ_WRITE_IN && st_r.tx_cnt != '0) begin
      st_nxt.tx_cnt = st_r.tx_cnt - 12'h001;
    end

    st_nxt.rdata = 8'h00;
    if (rd_stb && hi_zero_rd) begin
      unique case (rd_key)
        ircx_key(BANK_CNT, IDX_RXC_LO): st_nxt.rdata = st_r.rx_cnt[7:0];
        ircx_key(BANK_CNT, IDX_RXC_HI): st_nxt.rdata = {4'h0, st_r.rx_cnt[11:8]};
        ircx_key(BANK_CNT, IDX_FEP_LO): begin
          st_nxt.rdata       = st_r.fep[7:0];
          st_nxt.fep_hi_snap = st_r.fep[13:8];
        end
        ircx_key(BANK_CNT, IDX_FEP_HI): st_nxt.rdata = {2'h0, st_r.fep_hi_snap};
        ircx_key(BANK_CNT, IDX_TXC_LO): st_nxt.rdata = st_r.tx_cnt[7:0];
        ircx_key(BANK_CNT, IDX_TXC_HI): st_nxt.rdata = {4'h0, st_r.tx_cnt[11:8]};
        ircx_key(BANK_CFG, IDX_IRCFG):  st_nxt.rdata = st_r.ircfg;
        ircx_key(BANK_CFG, IDX_XCVR):   st_nxt.rdata = st_r.xcvr;
        default:                        st_nxt.rdata = 8'h00;
      endcase
    end

    // A software load of a count byte overrides that byte of a same-cycle decrement; the other byte keeps the decremented value.
    if (wr_stb && hi_zero_wr_r) begin
      unique case (wr_key)
        ircx_key(BANK_CNT, IDX_TXC_LO): st_nxt.tx_cnt[7:0]  = wbyte;
        ircx_key(BANK_CNT, IDX_TXC_HI): st_nxt.tx_cnt[11:8] = wbyte[3:0];
        ircx_key(BANK_CFG, IDX_IRCFG):  st_nxt.ircfg        = wbyte;
        ircx_key(BANK_CFG, IDX_XCVR):   st_nxt.xcvr         = wbyte;
        default:                        st_nxt.ircfg        = st_r.ircfg;
      endcase
    end

    st_nxt.shdn   = st_r.xcvr[XCVR_SHDN] || pd_eff;
    st_nxt.txd    = TXD_MOD_IN || st_r.xcvr[XCVR_TXD_FORCE];
    st_nxt.sir_rx = st_r.xcvr[XCVR_ECHO] ? TXD_MOD_IN : RX_PIN_IN;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      st_r        <= '0;
      st_r.rx_cnt <= RXC_RST;
      st_r.fep    <= FEP_RST;
      st_r.tx_cnt <= TXC_RST;
      st_r.ircfg  <= IRCFG_RST;
      st_r.xcvr   <= XCVR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_rx_count;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      (!RX_START_IN && RX_BYTE_IN) |=> (st_r.rx_cnt == $past(st_r.rx_cnt) + 12'h001);
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("receive count did not advance");

  property p_fep_load;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      RX_FRAME_END_IN |=> (st_r.fep == $past(RX_END_PTR_IN));
  endproperty
  a_fep_load: assert property (p_fep_load) else $error("frame end pointer not loaded");

  property p_fep_reset;
    @(posedge CLK_IN) $rose(RSTN_IN) |-> (st_r.fep == 14'h0000);
  endproperty
  a_fep_reset: assert property (p_fep_reset) else $error("frame end pointer not zero after reset");

  property p_fep_pair;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      (rd_stb && hi_zero_rd && rd_key == ircx_key(BANK_CNT, IDX_FEP_LO))
        ##1 (!(rd_stb && rd_key == ircx_key(BANK_CNT, IDX_FEP_LO)))
        ##1 (rd_stb && hi_zero_rd && rd_key == ircx_key(BANK_CNT, IDX_FEP_HI))
        |=> (HRDATA_OUT[5:0] == $past(st_r.fep[13:8], 3));
  endproperty
  a_fep_pair: assert property (p_fep_pair) else $error("pointer high byte not from snapshot");

  property p_tx_dec;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      (TXQ_WRITE_IN && st_r.tx_cnt != '0 && !wr_stb) |=> (st_r.tx_cnt == $past(st_r.tx_cnt) - 12'h001);
  endproperty
  a_tx_dec: assert property (p_tx_dec) else $error("transmit count did not decrement");

  property p_dma_stop;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      (st_r.tx_cnt == '0) |-> !TX_DMA_REQ_OUT;
  endproperty
  a_dma_stop: assert property (p_dma_stop) else $error("DMA request with zero count");

  property p_rate;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      (mode != MOD_FIR1) |-> (FIR_RATE_OUT == RATE_1152K);
  endproperty
  a_rate: assert property (p_rate) else $error("speed field not ignored outside fast mode");

  property p_shdn;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      (PWRDN_REQ_IN && !st_r.xcvr[XCVR_ACT]) |=> XCVR_SHDN_OUT;
  endproperty
  a_shdn: assert property (p_shdn) else $error("shutdown pin not forced in power-down");

  property p_echo;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      st_r.xcvr[XCVR_ECHO] |=> (SIR_RX_OUT == $past(TXD_MOD_IN));
  endproperty
  a_echo: assert property (p_echo) else $error("echo path not looped back");

  property p_inhibit;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      IR_ACT_OUT |-> !PWRDN_OUT;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("power-down while activity pin set");

  property p_txd_force;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      st_r.xcvr[XCVR_TXD_FORCE] |=> TXD_OUT;
  endproperty
  a_txd_force: assert property (p_txd_force) else $error("transmit pin not forced");

  property p_rx_clear;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      (RX_START_IN && !RX_BYTE_IN) |=> (st_r.rx_cnt == RXC_RST);
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive count not cleared on new reception");

  property p_mode_wr;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      (wr_stb && hi_zero_wr_r && wr_key == ircx_key(BANK_CFG, IDX_IRCFG))
        |=> (MODE_OUT == $past(HWDATA_IN[IRCFG_MOD_LSB+:4]));
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("modulation field not taken from write");

  property p_gpio_wr;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
      (wr_stb && hi_zero_wr_r && wr_key == ircx_key(BANK_CFG, IDX_XCVR))
        |=> ({GPIO_A_OUT, GPIO_D_OUT} == {$past(HWDATA_IN[XCVR_GPIO_A]), $past(HWDATA_IN[XCVR_GPIO_D])});
  endproperty
  a_gpio_wr: assert property (p_gpio_wr) else $error("general pins do not follow control write");

endmodule

// ==== verif/ircx_xcvr_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Optical transceiver: passes the far-end light level to the receive pin
// ----------------------------------------------------------------------
module ircx_xcvr_model (
  input  wire logic clk_in,
  input  wire logic shdn_in,
  input  wire logic light_in,
  output logic      rx_pin_out
);
  logic rx_q = 1'b0;

  // While shut down the receiver output is meaningless, so it toggles every cycle.
  always_ff @(posedge clk_in) begin
    rx_q <= shdn_in ? ~rx_q : light_in;
  end

  assign rx_pin_out = rx_q;
endmodule

// ==== verif/ir_counters_and_transceiver_control_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module ir_counters_and_transceiver_control_tb_top;
  import ircx_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        CLK_IN = 1'b0, RSTN_IN = 1'b0, HSEL_IN = 1'b0, HWRITE_IN = 1'b0;
  logic [31:0] HADDR_IN = 32'h0, HWDATA_IN = 32'h0, HRDATA_OUT;
  logic [1:0]  HTRANS_IN = 2'h0;
  logic [2:0]  HSIZE_IN = 3'h2;
  logic        RX_START_IN = 1'b0, RX_BYTE_IN = 1'b0, RX_FRAME_END_IN = 1'b0, TXQ_WRITE_IN = 1'b0;
  logic [13:0] RX_END_PTR_IN = 14'h0;
  logic        TX_DMA_RAW_IN = 1'b0, TXQ_EMPTY_IN = 1'b0, PWRDN_REQ_IN = 1'b0, TXD_MOD_IN = 1'b0;
  logic        RX_PIN_IN, light = 1'b1;
  logic        HREADYOUT_OUT, HRESP_OUT, TX_DMA_REQ_OUT, TX_DONE_OUT, PWRDN_OUT, SIR_RX_OUT, TXD_OUT;
  logic        GPIO_A_OUT, GPIO_B_OUT, GPIO_C_OUT, GPIO_D_OUT, XCVR_SHDN_OUT, IR_ACT_OUT;
  logic        USE_DIVISOR_OUT, CFG_RESERVED_OUT;
  logic [3:0]  MODE_OUT, FIR_RATE_OUT;
  int          mismatches = 0;
  int          num_checks = 0;

  always #12.5 CLK_IN = ~CLK_IN;

  ircx_regs i_ircx_regs (.CLK_IN, .RSTN_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN, .HWRITE_IN, .HSIZE_IN,
    .HWDATA_IN, .HREADY_IN(HREADYOUT_OUT), .HRDATA_OUT, .HREADYOUT_OUT, .HRESP_OUT, .RX_START_IN, .RX_BYTE_IN,
    .RX_FRAME_END_IN, .RX_END_PTR_IN, .TXQ_WRITE_IN, .TX_DMA_RAW_IN, .TXQ_EMPTY_IN, .TX_DMA_REQ_OUT,
    .TX_DONE_OUT, .PWRDN_REQ_IN, .PWRDN_OUT, .TXD_MOD_IN, .RX_PIN_IN, .SIR_RX_OUT, .TXD_OUT,
    .GPIO_A_OUT, .GPIO_B_OUT, .GPIO_C_OUT, .GPIO_D_OUT, .XCVR_SHDN_OUT, .IR_ACT_OUT, .MODE_OUT,
    .FIR_RATE_OUT, .USE_DIVISOR_OUT, .CFG_RESERVED_OUT);

  ircx_xcvr_model i_ircx_xcvr_model (.clk_in(CLK_IN), .shdn_in(XCVR_SHDN_OUT), .light_in(light),
    .rx_pin_out(RX_PIN_IN));

  // ----------------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------------
  task automatic bus(input logic wr, input logic [1:0] bk, input logic [2:0] ix, input logic [7:0] wd,
                     output logic [7:0] rd);
    align();
    HSEL_IN   <= 1'b1;
    HTRANS_IN <= HTRANS_NONSEQ;
    HADDR_IN  <= {25'h0, bk, ix, 2'b00};
    HWRITE_IN <= wr;
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    HTRANS_IN <= 2'h0;
    HWDATA_IN <= {24'h0, wd};
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    `CHK(HRESP_OUT, 1'b0)
    `CHK(HRDATA_OUT[31:8], 24'h0)
    rd = HRDATA_OUT[7:0];
  endtask

  task automatic wr(input logic [1:0] bk, input logic [2:0] ix, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, bk, ix, d, x);
  endtask

  task automatic rc(input logic [1:0] bk, input logic [2:0] ix, input logic [7:0] e);
    logic [7:0] x;
    bus(1'b0, bk, ix, 8'h00, x);
    `CHK(x, e)
  endtask

  task automatic settle();
    @(negedge CLK_IN);
  endtask

  // Waits for a rising edge unless one has just passed, so drives never change mid-cycle.
  task automatic align();
    if (CLK_IN !== 1'b1) @(posedge CLK_IN);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rc(BANK_CNT, IDX_FEP_LO, 8'h00);
    rc(BANK_CNT, IDX_FEP_HI, 8'h00);
    rc(BANK_CFG, IDX_XCVR, 8'h00);
    rc(2'h3, 3'h0, 8'h00);
    settle();
    `CHK(TXD_OUT, 1'b0)
  endtask

  task automatic t_rx();
    RX_START_IN <= 1'b1;
    RX_BYTE_IN  <= 1'b1;
    @(posedge CLK_IN);
    RX_START_IN <= 1'b0;
    repeat (12'h1a4) @(posedge CLK_IN);
    RX_BYTE_IN <= 1'b0;
    rc(BANK_CNT, IDX_RXC_LO, 8'ha5);
    rc(BANK_CNT, IDX_RXC_HI, 8'h01);
    wr(BANK_CNT, IDX_RXC_LO, 8'hff);
    rc(BANK_CNT, IDX_RXC_LO, 8'ha5);
    RX_START_IN <= 1'b1;
    @(posedge CLK_IN);
    RX_START_IN <= 1'b0;
    rc(BANK_CNT, IDX_RXC_LO, 8'h00);
  endtask

  task automatic frame_end(input logic [13:0] p);
    RX_END_PTR_IN   <= p;
    RX_FRAME_END_IN <= 1'b1;
    @(posedge CLK_IN);
    RX_FRAME_END_IN <= 1'b0;
  endtask

  task automatic t_fep();
    frame_end(14'h2abc);
    rc(BANK_CNT, IDX_FEP_LO, 8'hbc);
    frame_end(14'h1555);
    rc(BANK_CNT, IDX_FEP_HI, 8'h2a);
    rc(BANK_CNT, IDX_FEP_LO, 8'h55);
    rc(BANK_CNT, IDX_FEP_HI, 8'h15);
  endtask

  task automatic txq_writes(input int n);
    align();
    TXQ_WRITE_IN <= 1'b1;
    repeat (n) @(posedge CLK_IN);
    TXQ_WRITE_IN <= 1'b0;
  endtask

  task automatic t_tx();
    wr(BANK_CNT, IDX_TXC_LO, 8'h03);
    wr(BANK_CNT, IDX_TXC_HI, 8'h01);
    TX_DMA_RAW_IN <= 1'b1;
    txq_writes(3);
    rc(BANK_CNT, IDX_TXC_LO, 8'h00);
    rc(BANK_CNT, IDX_TXC_HI, 8'h01);
    settle();
    `CHK(TX_DMA_REQ_OUT, 1'b1)
    wr(BANK_CNT, IDX_TXC_LO, 8'h02);
    wr(BANK_CNT, IDX_TXC_HI, 8'h00);
    txq_writes(1);
    rc(BANK_CNT, IDX_TXC_LO, 8'h01);
    settle();
    `CHK(TX_DMA_REQ_OUT, 1'b1)
    txq_writes(1);
    settle();
    `CHK(TX_DMA_REQ_OUT, 1'b0)
    `CHK(TX_DONE_OUT, 1'b0)
    align();
    TXQ_EMPTY_IN <= 1'b1;
    settle();
    `CHK(TX_DONE_OUT, 1'b1)
    txq_writes(1);
    rc(BANK_CNT, IDX_TXC_LO, 8'h00);
    TX_DMA_RAW_IN <= 1'b0;
  endtask

  task automatic t_cfg();
    logic [3:0] m, s;
    for (int i = 0; i < 24; i++) begin
      m = 4'(i / 4);
      s = 4'(i % 4);
      wr(BANK_CFG, IDX_IRCFG, {s, m});
      rc(BANK_CFG, IDX_IRCFG, {s, m});
      settle();
      `CHK(MODE_OUT, m)
      `CHK(USE_DIVISOR_OUT, (m < 4'h2))
      `CHK(FIR_RATE_OUT, ((m == 4'h2) ? s : 4'h0))
      `CHK(CFG_RESERVED_OUT, ((m > 4'h4) || (m == 4'h2 && s > 4'h2)))
    end
  endtask

  task automatic t_xcvr();
    for (int b = 0; b < 8; b++) begin
      wr(BANK_CFG, IDX_XCVR, 8'h01 << b);
      rc(BANK_CFG, IDX_XCVR, 8'h01 << b);
      repeat (3) @(posedge CLK_IN);
      settle();
      `CHK({GPIO_A_OUT, GPIO_B_OUT, GPIO_C_OUT, GPIO_D_OUT}, {b == 7, b == 6, b == 5, b == 0})
      `CHK(XCVR_SHDN_OUT, (b == 4))
      `CHK(IR_ACT_OUT, (b == 2))
      `CHK(TXD_OUT, (b == 1))
      if (b != 4) begin
        `CHK(SIR_RX_OUT, (b != 3))
      end
    end
    wr(BANK_CFG, IDX_XCVR, 8'h08);
    TXD_MOD_IN <= 1'b1;
    repeat (2) @(posedge CLK_IN);
    settle();
    `CHK(SIR_RX_OUT, 1'b1)
    `CHK(TXD_OUT, 1'b1)
    align();
    TXD_MOD_IN <= 1'b0;
    wr(BANK_CFG, IDX_XCVR, 8'h00);
    PWRDN_REQ_IN <= 1'b1;
    repeat (3) @(posedge CLK_IN);
    settle();
    `CHK(PWRDN_OUT, 1'b1)
    `CHK(XCVR_SHDN_OUT, 1'b1)
    wr(BANK_CFG, IDX_XCVR, 8'h04);
    repeat (2) @(posedge CLK_IN);
    settle();
    `CHK(PWRDN_OUT, 1'b0)
    `CHK(XCVR_SHDN_OUT, 1'b0)
    align();
    PWRDN_REQ_IN <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge CLK_IN);
    RSTN_IN <= 1'b1;
    t_reset();
    t_rx();
    t_fep();
    t_tx();
    t_cfg();
    t_xcvr();
    report_and_stop();
  end

  // The whole run takes under 2000 cycles, so this limit only trips on a hang.
  initial begin
    #(25 * 20000);
    mismatches++;
    report_and_stop();
  end
endmodule
